/* File: pkg/ssc_pkg.sv */
/*
  Constants, register map, reset values and timing for the stall
  prevention / slip compensation supervisor. Assumes a 40 MHz hclk.
*/
// Contract
// - slip comp only for slip 0.01-50%, 0/9999 off
// - slip filter time constant 0.01-10 s, 0.5 default
// - above base freq compensate only at 9999
// - over stall level, alter output frequency
// - fast limit shuts output off on overcurrent
// - primary level 0.1-200%, 150% default, 0 off
// - factor 9999 keeps level constant, else reduces
// - second level 0-200%, 0 off, 9999 primary
// - second set select picks second level
// - reduction start frequency 0-400 Hz, 50 default
// - sentinel factor keeps level up to 400 Hz
// - selection code 0-31/100/101 picks operations
// - accel halts, const decelerates, decel halts; code decelerates during accel, accelerates during decel
// - alarm at least 100 ms, off at level
// - alarm delay 0 now, 0.1-25 s, 9999 never
// - regen avoidance or overvoltage stall drive alarm
// - terminal code 3 positive, 103 negative alarm
// - 1 Hz for 3 s raises fault, trips
// - settings writable while running, no protection
package ssc_pkg;
  // register indices, byte offset is index times four
  localparam int NREG      = 14;
  localparam int IX_SLIP   = 0;
  localparam int IX_TC     = 1;
  localparam int IX_CSEL   = 2;
  localparam int IX_PLVL   = 3;
  localparam int IX_COMP   = 4;
  localparam int IX_SLVL   = 5;
  localparam int IX_RSTART = 6;
  localparam int IX_SEL    = 7;
  localparam int IX_DLY    = 8;
  localparam int IX_TERMA  = 9;
  localparam int IX_TERMB  = 10;
  localparam int IX_TERMC  = 11;
  localparam int IX_FLIM   = 12;
  localparam int IX_BASE   = 13;
  localparam int IX_STAT   = 14;
  // status fields
  localparam int ST_STALL  = 0;
  localparam int ST_ALARM  = 1;
  localparam int ST_FAULT  = 2;
  localparam int ST_FAST   = 3;
  localparam int ST_SLIP   = 16;
  // value limits, units: slip 0.01%, time 0.01 s, level 0.1%,
  // frequency 0.01 Hz, alarm delay 0.1 s
  localparam logic [15:0] SENT     = 16'h270F;
  localparam logic [15:0] SLIP_MAX = 16'h1388;
  localparam logic [15:0] TC_MIN   = 16'h0001;
  localparam logic [15:0] TC_MAX   = 16'h03E8;
  localparam logic [15:0] LVL_MAX  = 16'h07D0;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] SEL_MAX  = 16'h001F;
  localparam logic [15:0] SEL_A    = 16'h0064;
  localparam logic [15:0] SEL_B    = 16'h0065;
  localparam logic [15:0] DLY_MAX  = 16'h00FA;
  localparam logic [15:0] TERM_POS = 16'h0003;
  localparam logic [15:0] TERM_NEG = 16'h0067;
  localparam logic [15:0] LOWF_FRQ = 16'h0064;
  localparam logic [47:0] SLIP_DIV = 48'h0000_0098_9680;
  // reset values in index order
  localparam logic [15:0] RST_VAL [NREG] = '{
    16'h270F, 16'h0032, 16'h270F, 16'h05DC, 16'h270F, 16'h270F,
    16'h1388, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h07D0, 16'h1388};
  // timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int T_TICK_MS  = 10;
  localparam int TICK_CYC   = CLK_HZ / 1000 * T_TICK_MS;
  localparam int T_HOLD_MS  = 100;
  localparam int HOLD_TICKS = T_HOLD_MS / T_TICK_MS;
  localparam int T_LOWF_MS  = 3000;
  localparam int LOWF_TICKS = T_LOWF_MS / T_TICK_MS;
  localparam int T_DLY_MS   = 100;
  localparam int DLY_TICKS  = T_DLY_MS / T_TICK_MS;
  // motion phase and frequency command codes
  localparam logic [1:0] PH_CONST  = 2'h0;
  localparam logic [1:0] PH_ACCEL  = 2'h1;
  localparam logic [1:0] PH_DECEL  = 2'h2;
  localparam logic [1:0] ADJ_NONE  = 2'h0;
  localparam logic [1:0] ADJ_DECEL = 2'h1;
  localparam logic [1:0] ADJ_ACCEL = 2'h2;
  // alarm sequencer
  typedef enum logic [1:0] {
    AL_IDLE = 2'b00,
    AL_WAIT = 2'b01,
    AL_ON   = 2'b11
  } ssc_alarm_t;
endpackage

/* File: rtl/ssc_top.sv */
/*
  Stall prevention and slip compensation supervisor with an
  AHB-Lite register slave. Assumes current and frequency come from
  logic on hclk; the three status pins are asynchronous.
*/
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ssc_top #(
  parameter int TICK_CYC = ssc_pkg::TICK_CYC
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // power stage measurements, same clock
  input  wire logic [15:0] out_current,
  input  wire logic [15:0] out_freq,
  input  wire logic [1:0]  accel_phase,
  // asynchronous pins
  input  wire logic        second_set_select,
  input  wire logic        regen_avoid_active,
  input  wire logic        overvoltage_stall_flag,
  // control outputs
  output logic             stall_active,
  output logic      [1:0]  freq_adjust,
  output logic             fast_limit_shutoff,
  output logic             stall_alarm_signal,
  output logic      [2:0]  term_out,
  output logic             low_freq_stall_fault,
  output logic      [15:0] slip_comp
);
  import ssc_pkg::*;

  // (a*b*c)/d, shared by level reduction and slip target
  function automatic logic [47:0] muldiv(input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] c, input logic [47:0] d);
    logic [47:0] p;
    p = 48'(a) * 48'(b) * 48'(c);
    muldiv = (d == 48'h0) ? 48'h0 : p / d;
  endfunction

  // value check per register; out-of-range writes are dropped
  function automatic logic legal(input logic [3:0] ix, input logic [15:0] v);
    case (ix)
      4'(IX_SLIP):   legal = v <= SLIP_MAX || v == SENT;
      4'(IX_TC):     legal = v >= TC_MIN && v <= TC_MAX;
      4'(IX_CSEL):   legal = v == 16'h0000 || v == SENT;
      4'(IX_PLVL):   legal = v <= LVL_MAX;
      4'(IX_COMP):   legal = v <= LVL_MAX || v == SENT;
      4'(IX_SLVL):   legal = v <= LVL_MAX || v == SENT;
      4'(IX_RSTART): legal = v <= FREQ_MAX;
      4'(IX_SEL):    legal = v <= SEL_MAX || v == SEL_A || v == SEL_B;
      4'(IX_DLY):    legal = v <= DLY_MAX || v == SENT;
      default:       legal = 1'b1;
    endcase
  endfunction

  // terminal routing of the alarm
  function automatic logic route(input logic [15:0] sel, input logic al);
    route = (sel == TERM_POS) ? al : (sel == TERM_NEG) ? ~al : 1'b0;
  endfunction

  logic [15:0] regs_r [NREG];
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        wr_pend_r;
  logic [3:0]  wr_ix_r;
  logic [31:0] hrdata_r;
  logic [18:0] tick_cnt_r;
  logic [15:0] dly_cnt_r;
  logic [15:0] dly_cnt_nxt;
  logic [3:0]  hold_cnt_r;
  logic [3:0]  hold_cnt_nxt;
  logic [8:0]  lowf_cnt_r;
  logic        stall_r;
  logic [1:0]  adj_r;
  logic        fast_r;
  logic        alarm_r;
  logic        fault_r;
  logic [2:0]  term_r;
  logic [15:0] slip_r;
  ssc_alarm_t  al_r;
  ssc_alarm_t  al_nxt;

  // bus decode; slave stalls only while the enable freezes it
  wire        addr_ok  = hsel & htrans[1] & hready & ce;
  wire [3:0]  a_ix     = haddr[5:2];
  wire        wr_data  = wr_pend_r & ce;
  wire [15:0] wd       = hwdata[15:0];
  wire        wr_reg   = wr_data && (wr_ix_r < 4'(NREG)) && legal(wr_ix_r, wd);
  wire        wr_stat  = wr_data && (wr_ix_r == 4'(IX_STAT));
  wire        fwd      = wr_reg && (wr_ix_r == a_ix);
  wire        a_map    = (haddr[31:6] == 26'h0) && (a_ix <= 4'(IX_STAT));
  wire [31:0] status   = {slip_r, 12'h000, fast_r, fault_r, alarm_r, stall_r};
  // indices past the map have no storage behind them
  wire [15:0] reg_rd   = fwd ? wd : (a_ix < 4'(NREG)) ? regs_r[a_ix] : 16'h0000;
  // unmapped reads return zero; writes fall away at index 15 only, haddr above bit 5 is not decoded for writes
  wire [31:0] rd_val   = !a_map ? 32'h0000_0000 :
                         (a_ix == 4'(IX_STAT)) ? status : {16'h0000, reg_rd};

  // synchronised pins
  wire        sec_s    = sync2_r[0];
  wire        regen_s  = sync2_r[1];
  wire        ovst_s   = sync2_r[2];

  // active stall level
  wire [15:0] plvl     = regs_r[IX_PLVL];
  wire [15:0] slvl     = regs_r[IX_SLVL];
  wire [15:0] rstart   = regs_r[IX_RSTART];
  wire [15:0] base_lvl = !sec_s ? plvl : (slvl == SENT) ? plvl : slvl;
  wire        reduce   = (regs_r[IX_COMP] != SENT) && (out_freq > rstart);
  wire [47:0] red_lvl  = muldiv(rstart, base_lvl, 16'h0001, 48'(out_freq));
  wire [15:0] act_lvl  = reduce ? red_lvl[15:0] : base_lvl;

  // selection code: bit0 no fast limit, bits1-3 phase masks, bit4 trip
  wire [15:0] sel      = regs_r[IX_SEL];
  wire [4:0]  code     = (sel == SEL_A) ? 5'h00 : (sel == SEL_B) ? 5'h01 : sel[4:0];
  wire        ph_ok    = (accel_phase == PH_ACCEL) ? !code[1] :
                         (accel_phase == PH_CONST) ? !code[2] :
                         (accel_phase == PH_DECEL) ? !code[3] : 1'b0;
  wire        stall_nx = (base_lvl != 16'h0000) && ph_ok && (out_current > act_lvl);
  wire [1:0]  adj_nx   = !stall_nx ? ADJ_NONE :
                         (accel_phase == PH_DECEL) ? ADJ_ACCEL : ADJ_DECEL;
  wire        fast_nx  = !code[0] && (out_current > regs_r[IX_FLIM]);

  // timing base
  wire        tick     = tick_cnt_r == 19'(TICK_CYC - 1);

  // alarm event sources include regeneration and overvoltage stall
  wire        evt      = stall_r | regen_s | ovst_s;
  wire [15:0] dly      = regs_r[IX_DLY];
  wire [15:0] dly_tgt  = 16'(dly * 16'(DLY_TICKS));
  wire        alarm_nx = (al_nxt == AL_ON);

  // one tick beyond the hold, since the first tick after entry may
  // come at once; the alarm never stands shorter than the full hold
  wire        hold_end = hold_cnt_r == 4'(HOLD_TICKS + 1);

  // low frequency stall and trip-with-alarm
  wire        lowf     = stall_r && (out_freq <= LOWF_FRQ);
  wire        lowf_hit = lowf && tick && (lowf_cnt_r == 9'(LOWF_TICKS - 1));
  wire        trip_al  = code[4] && alarm_nx && !alarm_r;
  wire        fault_nx = lowf_hit | trip_al | (fault_r & ~(wr_stat & hwdata[ST_FAULT]));

  // slip compensation target and first-order filter step
  wire [15:0] rslip    = regs_r[IX_SLIP];
  wire        slip_en  = (rslip != 16'h0000) && (rslip != SENT) &&
                         !((regs_r[IX_CSEL] == 16'h0000) && (out_freq > regs_r[IX_BASE]));
  wire [47:0] slip_raw = muldiv(out_freq, rslip, out_current, SLIP_DIV);
  wire [15:0] slip_tgt = !slip_en ? 16'h0000 :
                         (slip_raw > 48'h0000_0000_FFFF) ? 16'hFFFF : slip_raw[15:0];
  wire signed [16:0] slip_dif = $signed({1'b0, slip_tgt}) - $signed({1'b0, slip_r});
  wire signed [16:0] slip_stp = slip_dif / $signed({1'b0, regs_r[IX_TC]});

  // alarm sequencer: optional delay, then a held minimum on-time
  always_comb begin
    al_nxt       = al_r;
    dly_cnt_nxt  = dly_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    unique case (al_r)
      AL_IDLE: begin
        dly_cnt_nxt  = 16'h0000;
        hold_cnt_nxt = 4'h0;
        if (evt && dly != SENT) begin
          al_nxt = (dly == 16'h0000) ? AL_ON : AL_WAIT;
        end
      end
      AL_WAIT: begin
        if (!evt || dly == SENT) begin
          al_nxt = AL_IDLE;
        end else if (tick) begin
          dly_cnt_nxt = dly_cnt_r + 16'h0001;
          if (dly_cnt_nxt >= dly_tgt) begin
            al_nxt = AL_ON;
          end
        end
      end
      AL_ON: begin
        if (tick && !hold_end) begin
          hold_cnt_nxt = hold_cnt_r + 4'h1;
        end
        if (!evt && hold_end) begin
          al_nxt = AL_IDLE;
        end
      end
      default: al_nxt = AL_IDLE;
    endcase
  end

  // pin synchronisers, first stage feeds the second only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else if (ce) begin
      sync1_r <= {overvoltage_stall_flag, regen_avoid_active, second_set_select};
      sync2_r <= sync1_r;
    end
  end

  // bus phases; writes land in the data phase, read data is sampled early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ix_r   <= 4'h0;
      hrdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_r <= addr_ok & hwrite;
      wr_ix_r   <= a_ix;
      if (addr_ok && !hwrite) begin
        hrdata_r <= rd_val;
      end
    end
  end

  // settings, writable at any time including while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs_r[i] <= RST_VAL[i];
      end
    end else if (ce && wr_reg) begin
      regs_r[wr_ix_r] <= wd;
    end
  end

  // tick and low-frequency stall timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 19'h0;
      lowf_cnt_r <= 9'h0;
    end else if (ce) begin
      tick_cnt_r <= tick ? 19'h0 : tick_cnt_r + 19'h1;
      if (!lowf) begin
        lowf_cnt_r <= 9'h0;
      end else if (tick && lowf_cnt_r != 9'(LOWF_TICKS - 1)) begin
        lowf_cnt_r <= lowf_cnt_r + 9'h1;
      end
    end
  end

  // stall decision, alarm and fault state; a new fault beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_r    <= 1'b0;
      adj_r      <= ADJ_NONE;
      fast_r     <= 1'b0;
      al_r       <= AL_IDLE;
      dly_cnt_r  <= 16'h0000;
      hold_cnt_r <= 4'h0;
      alarm_r    <= 1'b0;
      fault_r    <= 1'b0;
      term_r     <= 3'h0;
    end else if (ce) begin
      stall_r    <= stall_nx;
      adj_r      <= adj_nx;
      fast_r     <= fast_nx;
      al_r       <= al_nxt;
      dly_cnt_r  <= dly_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      alarm_r    <= alarm_nx;
      fault_r    <= fault_nx;
      term_r     <= {route(regs_r[IX_TERMC], alarm_nx),
                     route(regs_r[IX_TERMB], alarm_nx),
                     route(regs_r[IX_TERMA], alarm_nx)};
    end
  end

  // slip filter moves 1/tc of the gap each 10 ms tick; truncation
  // leaves a residue below tc counts, accepted for area
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slip_r <= 16'h0000;
    end else if (ce && tick) begin
      slip_r <= 16'($signed({1'b0, slip_r}) + slip_stp);
    end
  end

  // outputs; a trip also forces the shutoff
  assign hrdata               = hrdata_r;
  assign hreadyout            = ce;
  assign hresp                = 1'b0;
  assign stall_active         = stall_r;
  assign freq_adjust          = adj_r;
  // plain gate of two flops, so a trip costs no extra cycle
  assign fast_limit_shutoff   = fast_r | fault_r;
  assign stall_alarm_signal   = alarm_r;
  assign term_out             = term_r;
  assign low_freq_stall_fault = fault_r;
  assign slip_comp            = slip_r;
endmodule

/* File: sim/ssc_sva.sv */
/*
  Checker for the stall supervisor ports.
  Assumes a bind from the bench and one hclk domain.
*/
`timescale 1ns/1ps
module ssc_sva #(
  parameter int TICK_CYC = 4
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hresp,
  // motor side
  input wire logic [15:0] out_current,
  input wire logic [1:0]  accel_phase,
  input wire logic        regen_avoid_active,
  input wire logic        overvoltage_stall_flag,
  input wire logic        stall_active,
  input wire logic [1:0]  freq_adjust,
  input wire logic        fast_limit_shutoff,
  input wire logic        stall_alarm_signal,
  input wire logic        low_freq_stall_fault
);
  import ssc_pkg::*;
  // the full hold, counted in clock cycles
  localparam int MIN_ON = HOLD_TICKS * TICK_CYC;
  int   on_cnt;
  int   quiet;
  logic wr_addr;
  assign wr_addr = hsel & htrans[1] & hwrite & hready;
  // alarm high time, and cycles since any alarm cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt <= 0;
      quiet  <= 0;
    end else begin
      on_cnt <= stall_alarm_signal ? on_cnt + 1 : 0;
      quiet  <= (stall_active | regen_avoid_active | overvoltage_stall_flag) ? 0 : quiet + 1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_fault_rise;
    $rose(low_freq_stall_fault);
  endsequence
  sequence s_clear_req;
    $past(wr_addr, 2) || $past(wr_addr, 3);
  endsequence
  property p_phase;
    stall_active |-> (($past(accel_phase) == PH_CONST) ? (freq_adjust == ADJ_DECEL) :
      ($past(accel_phase) == PH_ACCEL) ? (freq_adjust != ADJ_ACCEL) :
      (freq_adjust != ADJ_DECEL));
  endproperty
  AST_OKAY: assert property (hresp == 1'h0)
    else $error("bus answered with an error");
  AST_NO_CAUSE: assert property ((out_current == 16'h0 || accel_phase == 2'h3) |=> !stall_active)
    else $error("stall without overcurrent");
  AST_PHASE: assert property (p_phase)
    else $error("wrong steering for motion phase");
  AST_SHUT: assert property (out_current == 16'h0 |=> !fast_limit_shutoff || low_freq_stall_fault)
    else $error("shutoff without current");
  AST_HOLD: assert property ($fell(stall_alarm_signal) |-> on_cnt >= MIN_ON)
    else $error("alarm pulse too short");
  AST_CAUSE: assert property ($rose(stall_alarm_signal) |-> quiet < 8)
    else $error("alarm without a cause");
  AST_TRIP: assert property (s_fault_rise |-> fast_limit_shutoff)
    else $error("fault without output trip");
  AST_KEEP: assert property ($fell(low_freq_stall_fault) |-> s_clear_req)
    else $error("fault dropped without clear");
endmodule

/* File: sim/ssc_motor.sv */
/*
  Motor and power stage model: current follows the bench load,
  frequency follows the command or the supervisor's steering.
*/
`timescale 1ns/1ps
module ssc_motor (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // steering and bench load
  input  wire logic [1:0]  freq_adjust,
  input  wire logic [15:0] load_cur,
  input  wire logic [1:0]  cmd_ph,
  input  wire logic [15:0] cmd_freq,
  // measurements
  output logic      [15:0] out_current,
  output logic      [15:0] out_freq,
  output logic      [1:0]  accel_phase
);
  import ssc_pkg::*;
  // slew one step a cycle while steered; a stalled drive bottoms out at 1 Hz
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_current <= 16'h0;
      out_freq    <= 16'h0;
      accel_phase <= PH_CONST;
    end else begin
      out_current <= load_cur;
      accel_phase <= cmd_ph;
      if (freq_adjust == ADJ_ACCEL) begin
        out_freq <= out_freq + 16'h1;
      end else if (freq_adjust == ADJ_DECEL) begin
        out_freq <= (out_freq > LOWF_FRQ) ? out_freq - 16'h1 : out_freq;
      end else begin
        out_freq <= cmd_freq;
      end
    end
  end
endmodule

/* File: sim/testbench.sv */
/*
  Bench top: bus tasks, motor model, scenario list.
  Assumes the supervisor runs with a 4 cycle tick.
*/
`timescale 1ns/1ps
module testbench;
  import ssc_pkg::*;
  localparam int TK = 4;
  // range writes, refused or accepted: index, data, value read back
  localparam int          RIX [6] = '{IX_SLIP, IX_PLVL, IX_SEL, IX_SEL, IX_DLY, IX_SEL};
  localparam logic [15:0] RWD [6] = '{16'h1389, 16'h7D1, 16'h20, 16'h65, 16'hFB, 16'h64};
  localparam logic [15:0] REX [6] = '{16'h270F, 16'h5DC, 16'h0, 16'h65, 16'h0, 16'h64};
  // selection code, phase, stall expected
  localparam logic [15:0] CCD [8] = '{16'h0, 16'h2, 16'h4, 16'h8, 16'h8, 16'h65, 16'h64, 16'h0};
  localparam logic [1:0]  CPH [8] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
  localparam logic [0:7]  CST     = 8'h8F;
  logic        hclk, hresetn, hsel, hwrite, second_set_select, hreadyout, hresp;
  logic        regen_avoid_active, overvoltage_stall_flag, stall_active;
  logic        fast_limit_shutoff, stall_alarm_signal, low_freq_stall_fault;
  logic [1:0]  htrans, freq_adjust, accel_phase, cmd_ph;
  logic [2:0]  term_out;
  logic [15:0] out_current, out_freq, slip_comp, load_cur, cmd_freq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          mismatches = 0;
  int          n_tests = 0;
  ssc_top #(.TICK_CYC(TK)) u_ssc_top (.hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .out_current, .out_freq, .accel_phase, .second_set_select, .regen_avoid_active,
    .overvoltage_stall_flag, .stall_active, .freq_adjust, .fast_limit_shutoff,
    .stall_alarm_signal, .term_out, .low_freq_stall_fault, .slip_comp);
  ssc_motor u_ssc_motor (.hclk, .hresetn, .freq_adjust, .load_cur, .cmd_ph, .cmd_freq,
    .out_current, .out_freq, .accel_phase);
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one single transfer; hold each phase until hready is seen high
  task automatic bus(logic w, int ix, logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= 32'(ix * 4);
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(int ix, logic [31:0] d);
    bus(1'h1, ix, d);
  endtask
  // six cycles cover the pin synchronisers and the output flops
  task automatic mot(logic [15:0] c, logic [1:0] p, logic [15:0] f);
    load_cur <= c;
    cmd_ph   <= p;
    cmd_freq <= f;
    repeat (6) @(posedge hclk);
  endtask
  task automatic slp(int ix, logic [15:0] v, logic [15:0] f, logic [15:0] e);
    wr(ix, v);
    mot(16'h3E8, PH_CONST, f);
    repeat (3 * TK) @(posedge hclk);
    chk("slip", slip_comp, e);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end
  // hang guard, far beyond the few thousand cycles the list needs
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, second_set_select} = '0;
    {regen_avoid_active, overvoltage_stall_flag, load_cur, cmd_ph, cmd_freq} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int i = 0; i < NREG; i++) begin
      bus(1'h0, i, '0);
      chk("reset", rd, RST_VAL[i]);
    end
    // out of range writes dropped while the motor runs
    mot(16'h0, PH_CONST, 16'h1388);
    for (int i = 0; i < 6; i++) begin
      wr(RIX[i], RWD[i]);
      bus(1'h0, RIX[i], '0);
      chk("range", rd, REX[i]);
    end
    wr(15, '1);
    bus(1'h0, 15, '0);
    chk("unmapped", rd, 32'h0);
    // stall at constant speed, alarm on terminals A (pos), B and C (neg)
    wr(IX_TERMA, 32'h3);
    wr(IX_TERMB, 32'h67);
    wr(IX_TERMC, 32'h67);
    mot(16'h640, PH_CONST, 16'h1388);
    chk("stall", {stall_active, freq_adjust}, {1'h1, ADJ_DECEL});
    chk("alarm", {stall_alarm_signal, term_out}, 4'h9);
    mot(16'h578, PH_CONST, 16'h1388);
    chk("hold", stall_alarm_signal, 1'h1);
    repeat ((HOLD_TICKS + 2) * TK) @(posedge hclk);
    chk("off", {stall_active, stall_alarm_signal, term_out}, 5'h06);
    for (int i = 0; i < 8; i++) begin
      wr(IX_SEL, CCD[i]);
      mot(16'h640, CPH[i], 16'h1388);
      chk("code", stall_active, CST[i]);
      mot(16'h0, PH_CONST, 16'h1388);
    end
    // second level by pin, zero primary level disables
    wr(IX_SLVL, 32'h3E8);
    second_set_select <= 1'h1;
    mot(16'h4B0, PH_CONST, 16'h1388);
    chk("second", stall_active, 1'h1);
    second_set_select <= 1'h0;
    mot(16'h4B0, PH_CONST, 16'h1388);
    chk("primary", stall_active, 1'h0);
    wr(IX_PLVL, 32'h0);
    mot(16'h640, PH_CONST, 16'h1388);
    chk("zero", stall_active, 1'h0);
    wr(IX_PLVL, 32'h5DC);
    // 0.1 s alarm delay restarts on a gap, 9999 never, regen drives it
    mot(16'h0, PH_CONST, 16'h1388);
    repeat (2 * HOLD_TICKS * TK) @(posedge hclk);
    wr(IX_DLY, 32'h1);
    mot(16'h640, PH_CONST, 16'h1388);
    repeat (6 * TK) @(posedge hclk);
    mot(16'h0, PH_CONST, 16'h1388);
    mot(16'h640, PH_CONST, 16'h1388);
    repeat (5 * TK) @(posedge hclk);
    chk("early", stall_alarm_signal, 1'h0);
    repeat (7 * TK) @(posedge hclk);
    chk("late", stall_alarm_signal, 1'h1);
    mot(16'h0, PH_CONST, 16'h1388);
    repeat (2 * HOLD_TICKS * TK) @(posedge hclk);
    wr(IX_DLY, 32'h270F);
    mot(16'h640, PH_CONST, 16'h1388);
    repeat (12 * TK) @(posedge hclk);
    chk("never", stall_alarm_signal, 1'h0);
    mot(16'h0, PH_CONST, 16'h1388);
    wr(IX_DLY, 32'h0);
    regen_avoid_active <= 1'h1;
    repeat (6) @(posedge hclk);
    chk("regen", stall_alarm_signal, 1'h1);
    regen_avoid_active <= 1'h0;
    // fast limit at 170 %, code 1 drops it
    wr(IX_FLIM, 32'h6A4);
    mot(16'h708, PH_CONST, 16'h1388);
    chk("fast", fast_limit_shutoff, 1'h1);
    wr(IX_SEL, 32'h1);
    mot(16'h708, PH_CONST, 16'h1388);
    chk("nofast", fast_limit_shutoff, 1'h0);
    wr(IX_SEL, 32'h0);
    wr(IX_COMP, 32'h64);
    mot(16'h3E8, PH_DECEL, 16'h2710);
    chk("reduce", stall_active, 1'h1);
    wr(IX_COMP, 32'h270F);
    mot(16'h3E8, PH_DECEL, 16'h9C40);
    chk("flat", stall_active, 1'h0);
    wr(IX_TC, 32'h1);
    slp(IX_SLIP, 16'h64, 16'h1388, 16'h32);
    slp(IX_CSEL, 16'h0, 16'h1770, 16'h0);
    slp(IX_CSEL, 16'h270F, 16'h1770, 16'h3C);
    slp(IX_SLIP, 16'h270F, 16'h1770, 16'h0);
    // trip-with-alarm codes fault as the alarm turns on
    wr(IX_SEL, 32'h10);
    mot(16'h640, PH_CONST, 16'h1388);
    chk("tripsel", low_freq_stall_fault, 1'h1);
    mot(16'h0, PH_CONST, 16'h12C);
    wr(IX_STAT, 32'h4);
    wr(IX_SEL, 32'h0);
    // pulled to 1 Hz and held 3 s trips; status bit cleared by write
    mot(16'h640, PH_CONST, 16'h12C);
    repeat (LOWF_TICKS * TK + 300) @(posedge hclk);
    chk("trip", {low_freq_stall_fault, fast_limit_shutoff}, 2'h3);
    mot(16'h0, PH_CONST, 16'h1388);
    bus(1'h0, IX_STAT, '0);
    chk("stat", rd[2], 1'h1);
    wr(IX_STAT, 32'h4);
    bus(1'h0, IX_STAT, '0);
    chk("clear", {rd[2], low_freq_stall_fault}, 2'h0);
    test_done();
  end
endmodule
bind ssc_top ssc_sva #(.TICK_CYC(TICK_CYC)) u_ssc_sva (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hresp, .out_current, .accel_phase, .regen_avoid_active,
  .overvoltage_stall_flag, .stall_active, .freq_adjust, .fast_limit_shutoff,
  .stall_alarm_signal, .low_freq_stall_fault);
